// ---- rtl/isx_exec.sv ----
// Summary of operation
// - first move form: prefix, offset, then absolute destination
// - source address is stack pointer plus offset
// - computed addresses wrap across full 12-bit space
// - indirect source register reads as zero
// - second move form: destination is pointer plus offset
// - indirect destination makes the second-form move a no-op
// - push writes literal at pointer, then decrements
// - subtract literal from selected pointer, flags untouched
// - selector three: subtract from stack pointer, return
// - return takes two cycles, second is no-op
// - extended opcodes only when config bit set
`timescale 1ns/1ns
module isx_exec (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic extended_set_config_bit,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] mem_rd_data,
  output logic instr_take,
  output logic [11:0] mem_rd_addr,
  output logic [11:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  output logic mem_wr_en,
  output logic return_load,
  output logic ext_claimed,
  output logic busy,
  output logic [11:0] file_select_pointer0,
  output logic [11:0] file_select_pointer1,
  output logic [11:0] software_stack_pointer
);

  function automatic logic is_indirect(input logic [11:0] a);
    is_indirect =
      (a <= isx_pkg::IND0_TOP && a > isx_pkg::IND0_TOP - isx_pkg::IND_SPAN) ||
      (a <= isx_pkg::IND1_TOP && a > isx_pkg::IND1_TOP - isx_pkg::IND_SPAN) ||
      (a <= isx_pkg::IND2_TOP && a > isx_pkg::IND2_TOP - isx_pkg::IND_SPAN);
  endfunction : is_indirect

  function automatic logic [11:0] offs_addr(input logic [11:0] base,
                                            input logic [6:0] off);
    offs_addr = base + {5'h00, off};
  endfunction : offs_addr

  logic [1:0] phase;
  logic q1;
  logic q4;

  isx_phase u_phase (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .phase(phase),
    .q1(q1),
    .q4(q4)
  );

  isx_pkg::isx_state_t state;
  isx_pkg::isx_state_t next_state;
  logic [15:0] word;
  logic [15:0] next_word;
  logic [11:0] ptr [0:2];
  logic [11:0] next_ptr [0:2];
  logic [11:0] rd_addr;
  logic [11:0] next_rd_addr;
  logic [11:0] wr_addr;
  logic [11:0] next_wr_addr;
  logic [7:0] rd_hold;
  logic [7:0] next_rd_hold;
  logic [7:0] wr_data;
  logic [7:0] next_wr_data;
  logic wr_pend;
  logic next_wr_pend;
  logic ss_kind;
  logic next_ss_kind;

  logic ext_idle;
  logic dec_move;
  logic dec_push;
  logic dec_sub;
  logic dec_ret;
  logic second_ok;
  logic [1:0] sel;
  logic [11:0] lit12;
  logic [6:0] off7;
  logic [11:0] dest_addr;
  logic dest_ind;
  logic src_ind;

  assign sel = word[isx_pkg::SEL_HI:isx_pkg::SEL_LO];
  assign lit12 = {6'h00, word[isx_pkg::LIT6_HI:0]};
  assign off7 = word[isx_pkg::OFF7_HI:0];
  // extended decode only with the config bit set
  assign ext_idle = extended_set_config_bit &&
                    (state == isx_pkg::ST_IDLE);
  assign dec_move = ext_idle &&
    (word[isx_pkg::OPC_HI:isx_pkg::OPC_LO] == isx_pkg::OP_MOVE_HI);
  assign dec_push = ext_idle &&
    (word[isx_pkg::OPC_HI:isx_pkg::OPC_LO] == isx_pkg::OP_PUSH_HI);
  assign dec_sub = ext_idle &&
    (word[isx_pkg::OPC_HI:isx_pkg::OPC_LO] == isx_pkg::OP_SUB_HI) &&
    (sel != isx_pkg::SEL_RETURN);
  assign dec_ret = ext_idle &&
    (word[isx_pkg::OPC_HI:isx_pkg::OPC_LO] == isx_pkg::OP_SUB_HI) &&
    (sel == isx_pkg::SEL_RETURN);
  assign second_ok =
    (word[isx_pkg::OPC_HI:isx_pkg::PREFIX_LO] == isx_pkg::SECOND_PREFIX);
  // absolute or stack relative destination
  assign dest_addr = ss_kind ? offs_addr(ptr[2], off7)
                             : word[isx_pkg::FADDR_HI:0];
  assign dest_ind = is_indirect(dest_addr);
  assign src_ind = is_indirect(rd_addr);

  always_comb begin
    next_state = state;
    next_word = word;
    next_rd_addr = rd_addr;
    next_wr_addr = wr_addr;
    next_rd_hold = rd_hold;
    next_wr_data = wr_data;
    next_wr_pend = wr_pend;
    next_ss_kind = ss_kind;
    for (int i = 0; i < isx_pkg::PTR_COUNT; i++) begin
      next_ptr[i] = ptr[i];
    end
    if (q1) begin
      next_word = instr_valid ? instr_word : isx_pkg::NOP_WORD;
    end
    if (phase == isx_pkg::PH_Q2) begin
      case (state)
        isx_pkg::ST_IDLE: begin
          if (dec_move) begin
            next_rd_addr = offs_addr(ptr[2], off7);
          end
          if (dec_push) begin
            next_wr_addr = ptr[2];
            next_wr_data = word[isx_pkg::LIT8_HI:0];
            next_wr_pend = 1'b1;
          end
        end
        isx_pkg::ST_SECOND: begin
          next_wr_addr = dest_addr;
          next_wr_data = rd_hold;
          next_wr_pend = second_ok && !(ss_kind && dest_ind);
        end
        default: begin
          next_wr_pend = 1'b0;
        end
      endcase
    end
    if (q4) begin
      next_wr_pend = 1'b0;
      case (state)
        isx_pkg::ST_IDLE: begin
          if (dec_move) begin
            // source read closes the first cycle
            next_rd_hold = src_ind ? isx_pkg::IND_READ_VALUE
                                   : mem_rd_data;
            next_ss_kind = word[isx_pkg::MOVE_KIND_BIT];
            next_state = isx_pkg::ST_SECOND;
          end
          if (dec_push) begin
            next_ptr[2] = ptr[2] - isx_pkg::PTR_STEP;
          end
          for (int i = 0; i < isx_pkg::PTR_COUNT; i++) begin
            if (dec_sub && sel == 2'(i)) begin
              next_ptr[i] = ptr[i] - lit12;
            end
          end
          if (dec_ret) begin
            next_ptr[2] = ptr[2] - lit12;
            next_state = isx_pkg::ST_RETNOP;
          end
        end
        default: begin
          next_state = isx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= isx_pkg::ST_IDLE;
      word <= isx_pkg::NOP_WORD;
      rd_addr <= isx_pkg::PTR_RESET;
      wr_addr <= isx_pkg::PTR_RESET;
      rd_hold <= isx_pkg::DATA_RESET;
      wr_data <= isx_pkg::DATA_RESET;
      wr_pend <= 1'b0;
      ss_kind <= 1'b0;
      for (int i = 0; i < isx_pkg::PTR_COUNT; i++) begin
        ptr[i] <= isx_pkg::PTR_RESET;
      end
    end else begin
      state <= next_state;
      word <= next_word;
      rd_addr <= next_rd_addr;
      wr_addr <= next_wr_addr;
      rd_hold <= next_rd_hold;
      wr_data <= next_wr_data;
      wr_pend <= next_wr_pend;
      ss_kind <= next_ss_kind;
      for (int i = 0; i < isx_pkg::PTR_COUNT; i++) begin
        ptr[i] <= next_ptr[i];
      end
    end
  end

  assign instr_take = q1;
  assign mem_rd_addr = rd_addr;
  assign mem_wr_addr = wr_addr;
  assign mem_wr_data = wr_data;
  // write lands at the Q4 edge
  assign mem_wr_en = wr_pend && q4;
  assign return_load = dec_ret && q4;
  assign ext_claimed = dec_move || dec_push || dec_sub || dec_ret ||
                       (state != isx_pkg::ST_IDLE);
  assign busy = (state != isx_pkg::ST_IDLE);
  assign file_select_pointer0 = ptr[0];
  assign file_select_pointer1 = ptr[1];
  assign software_stack_pointer = ptr[2];

  property p_push;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && dec_push) |-> (mem_wr_en && mem_wr_addr == software_stack_pointer
      && mem_wr_data == word[7:0]) ##1
      (software_stack_pointer == $past(software_stack_pointer) - 12'h001);
  endproperty
  a_push: assert property (p_push) else $error("push write wrong");

  property p_sub0;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && dec_sub && sel == 2'h0) |=>
      (file_select_pointer0 == $past(file_select_pointer0) - $past(lit12))
      && $stable(software_stack_pointer);
  endproperty
  a_sub0: assert property (p_sub0) else $error("subtract wrong");

  property p_ret;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && dec_ret) |-> return_load ##1 (state == isx_pkg::ST_RETNOP &&
      software_stack_pointer == $past(software_stack_pointer) - $past(lit12)
      && $stable(file_select_pointer0) && $stable(file_select_pointer1));
  endproperty
  a_ret: assert property (p_ret) else $error("return form wrong");

  property p_retnop;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(state == isx_pkg::ST_RETNOP) |->
      (state == isx_pkg::ST_RETNOP && !mem_wr_en && !return_load)[*4]
      ##1 (state == isx_pkg::ST_IDLE);
  endproperty
  a_retnop: assert property (p_retnop) else $error("no-op cycle");

  property p_src_addr;
    @(posedge core_clk) disable iff (!reset_n)
    (phase == isx_pkg::PH_Q3 && dec_move) |->
      (mem_rd_addr == software_stack_pointer + {5'h00, off7});
  endproperty
  a_src_addr: assert property (p_src_addr) else $error("src addr");

  property p_src_ind;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && dec_move) |=>
      (rd_hold == ($past(src_ind) ? 8'h00 : $past(mem_rd_data)));
  endproperty
  a_src_ind: assert property (p_src_ind) else $error("src value");

  property p_sf_dest;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && state == isx_pkg::ST_SECOND && !ss_kind && second_ok) |->
      (mem_wr_en && mem_wr_addr == word[11:0] && mem_wr_data == rd_hold);
  endproperty
  a_sf_dest: assert property (p_sf_dest) else $error("abs dest");

  property p_ss_dest;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && state == isx_pkg::ST_SECOND && ss_kind && second_ok && !dest_ind)
      |-> (mem_wr_en && mem_wr_addr ==
           software_stack_pointer + {5'h00, off7});
  endproperty
  a_ss_dest: assert property (p_ss_dest) else $error("idx dest");

  property p_ss_ind;
    @(posedge core_clk) disable iff (!reset_n)
    (state == isx_pkg::ST_SECOND && ss_kind && dest_ind && q4) |->
      !mem_wr_en ##1 (state == isx_pkg::ST_IDLE);
  endproperty
  a_ss_ind: assert property (p_ss_ind) else $error("ind dest");

  property p_move_len;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && dec_move) |=> (state == isx_pkg::ST_SECOND)[*4]
      ##1 (state == isx_pkg::ST_IDLE);
  endproperty
  a_move_len: assert property (p_move_len) else $error("move len");

  property p_disabled;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && !extended_set_config_bit && state == isx_pkg::ST_IDLE) |->
      (!mem_wr_en && !return_load) ##1 ($stable(software_stack_pointer) &&
      $stable(file_select_pointer0) && state == isx_pkg::ST_IDLE);
  endproperty
  a_disabled: assert property (p_disabled) else $error("ext off");

  property p_lone;
    @(posedge core_clk) disable iff (!reset_n)
    (q4 && state == isx_pkg::ST_IDLE && second_ok &&
     word[15:8] != isx_pkg::OP_PUSH_HI) |->
      (!mem_wr_en && !return_load) ##1 (state == isx_pkg::ST_IDLE &&
      $stable(software_stack_pointer));
  endproperty
  a_lone: assert property (p_lone) else $error("lone word");

endmodule : isx_exec

// ---- rtl/isx_pkg.sv ----
package isx_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int PTR_COUNT = 3;

  // opcode high bytes and field layout
  localparam logic [7:0] OP_MOVE_HI = 8'hEB;
  localparam logic [7:0] OP_SUB_HI = 8'hE9;
  localparam logic [7:0] OP_PUSH_HI = 8'hFA;
  localparam logic [3:0] SECOND_PREFIX = 4'hF;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int PREFIX_LO = 12;
  localparam int MOVE_KIND_BIT = 7;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int LIT6_HI = 5;
  localparam int OFF7_HI = 6;
  localparam int LIT8_HI = 7;
  localparam int FADDR_HI = 11;
  localparam logic [WORD_W-1:0] NOP_WORD = 16'h0000;

  // indirect addressing registers: three groups of five, top address each
  localparam logic [ADDR_W-1:0] IND0_TOP = 12'hFEF;
  localparam logic [ADDR_W-1:0] IND1_TOP = 12'hFE7;
  localparam logic [ADDR_W-1:0] IND2_TOP = 12'hFDF;
  localparam logic [ADDR_W-1:0] IND_SPAN = 12'h005;

  // reset values, indirect read value and pointer step
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] IND_READ_VALUE = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;

  // quarter phases of one instruction cycle, one core clock each
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SECOND = 2'b01,
    ST_RETNOP = 2'b11
  } isx_state_t;

endpackage : isx_pkg

// ---- rtl/isx_phase.sv ----
`timescale 1ns/1ns
module isx_phase (
  input wire logic core_clk,
  input wire logic reset_n,
  output logic [1:0] phase,
  output logic q1,
  output logic q4
);

  logic [1:0] next_phase;

  // free running quarter counter
  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      phase <= isx_pkg::PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  assign q1 = (phase == isx_pkg::PH_Q1);
  assign q4 = (phase == isx_pkg::PH_Q4);

endmodule : isx_phase

// ---- tb/isx_mem_model.sv ----
`timescale 1ns/1ns
module isx_mem_model (
  input wire logic core_clk,
  input wire logic [11:0] mem_rd_addr,
  input wire logic [11:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  input wire logic mem_wr_en,
  output logic [7:0] mem_rd_data
);
  logic [7:0] data [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) data[i] = 8'h00;
  end
  // combinational read of the full 4096-byte space
  assign mem_rd_data = data[mem_rd_addr];
  // write lands at the edge closing the fourth quarter
  always @(posedge core_clk) begin
    if (mem_wr_en === 1'b1) data[mem_wr_addr] <= mem_wr_data;
  end
endmodule : isx_mem_model

// ---- tb/indexed_stack_instr_exec_tb_top.sv ----
`timescale 1ns/1ns
module indexed_stack_instr_exec_tb_top;
  typedef struct {
    logic [15:0] w;
    logic [11:0] f0, f1, sp, a;
    logic [7:0] d;
  } isx_row_t;
  logic core_clk = 1'b0;
  logic reset_n, cfg, instr_valid, instr_take, mem_wr_en, return_load, busy;
  logic claim;
  logic [15:0] instr_word;
  logic [7:0] mem_rd_data, mem_wr_data;
  logic [11:0] mem_rd_addr, mem_wr_addr, fsp0, fsp1, ssp;
  logic [11:0] writes = 12'h000;
  logic [11:0] rets = 12'h000;
  logic [11:0] n, r;
  int failures = 0;
  int compares = 0;
  isx_row_t rows [5] = '{
    '{16'hE905, 12'hFFB, 12'h000, 12'h000, 12'h000, 8'h00},
    '{16'hE94A, 12'hFFB, 12'hFF6, 12'h000, 12'h000, 8'h00},
    '{16'hE9BF, 12'hFFB, 12'hFF6, 12'hFC1, 12'h000, 8'h00},
    '{16'hFA5A, 12'hFFB, 12'hFF6, 12'hFC0, 12'hFC1, 8'h5A},
    '{16'hFAA5, 12'hFFB, 12'hFF6, 12'hFBF, 12'hFC0, 8'hA5}};

  always #4 core_clk = ~core_clk;

  isx_exec DUT (.core_clk(core_clk), .reset_n(reset_n),
    .extended_set_config_bit(cfg), .instr_valid(instr_valid),
    .instr_word(instr_word), .mem_rd_data(mem_rd_data),
    .instr_take(instr_take), .mem_rd_addr(mem_rd_addr),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_en(mem_wr_en), .return_load(return_load), .ext_claimed(claim),
    .busy(busy), .file_select_pointer0(fsp0), .file_select_pointer1(fsp1),
    .software_stack_pointer(ssp));

  isx_mem_model mem (.core_clk(core_clk), .mem_rd_addr(mem_rd_addr),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_en(mem_wr_en), .mem_rd_data(mem_rd_data));

  // counts write strobes and return pulses
  always @(posedge core_clk) begin
    if (mem_wr_en === 1'b1) writes <= writes + 12'h001;
    if (return_load === 1'b1) rets <= rets + 12'h001;
  end

  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t value %h expected %h", $time, s, e);
    end
  endtask : chk

  function automatic logic [11:0] m(input logic [11:0] a);
    return {4'h0, mem.data[a]};
  endfunction : m

  task automatic take();
    int k;
    k = 0;
    while (instr_take !== 1'b1 && k < 8) begin
      @(negedge core_clk);
      k++;
    end
  endtask : take

  // idle word lines show the inverse of the last word
  task automatic issue(input logic [15:0] w);
    take();
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge core_clk);
    instr_valid = 1'b0;
    instr_word = ~w;
  endtask : issue

  task automatic summarize();
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  initial begin
    #6000;
    failures++;
    summarize();
  end

  initial begin
    reset_n = 1'b0;
    cfg = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    repeat (10) @(negedge core_clk);
    mem.data[12'hFCF] = 8'h3C;
    mem.data[12'hFE3] = 8'h99;
    mem.data[12'h124] = 8'h77;
    mem.data[12'hFEB] = 8'h55;
    mem.data[12'h03E] = 8'hE7;
    reset_n = 1'b1;
    chk(ssp, 12'h000);
    chk({11'h000, busy}, 12'h000);
    foreach (rows[i]) begin
      issue(rows[i].w);
      chk({11'h000, claim}, 12'h001);
      take();
      chk(fsp0, rows[i].f0);
      chk(fsp1, rows[i].f1);
      chk(ssp, rows[i].sp);
      chk(m(rows[i].a), {4'h0, rows[i].d});
    end
    // move destinations stay clear of program counter and return bytes
    issue(16'hEB10);
    take();
    chk({11'h000, busy}, 12'h001);
    issue(16'hF123);
    take();
    chk(m(12'h123), 12'h03C);
    issue(16'hEB24);
    issue(16'hF124);
    take();
    chk(m(12'h124), 12'h000);
    issue(16'hEB90);
    issue(16'hF011);
    take();
    chk(m(12'hFD0), 12'h03C);
    n = writes;
    issue(16'hEB90);
    issue(16'hF02C);
    take();
    chk(m(12'hFEB), 12'h055);
    chk(writes - n, 12'h000);
    issue(16'hEB7F);
    issue(16'hF000);
    take();
    chk(m(12'h000), 12'h0E7);
    n = writes;
    issue(16'hEB10);
    issue(16'h0123);
    take();
    chk(writes - n, 12'h000);
    chk(m(12'h123), 12'h03C);
    n = writes;
    issue(16'hF123);
    chk({11'h000, claim}, 12'h000);
    take();
    chk(writes - n, 12'h000);
    cfg = 1'b0;
    r = rets;
    issue(16'hFA11);
    chk({11'h000, claim}, 12'h000);
    issue(16'hE9C1);
    take();
    chk(writes - n, 12'h000);
    chk(rets - r, 12'h000);
    chk(ssp, 12'hFBF);
    cfg = 1'b1;
    issue(16'hE9C1);
    take();
    chk({11'h000, busy}, 12'h001);
    issue(16'hFA33);
    take();
    chk(ssp, 12'hFBE);
    chk(rets - r, 12'h001);
    chk(writes - n, 12'h000);
    reset_n = 1'b0;
    @(negedge core_clk);
    chk(ssp, 12'h000);
    chk(fsp0, 12'h000);
    chk(fsp1, 12'h000);
    reset_n = 1'b1;
    issue(16'hFA01);
    take();
    chk(ssp, 12'hFFF);
    chk(m(12'h000), 12'h001);
    summarize();
  end
endmodule : indexed_stack_instr_exec_tb_top
